// ==== verilog/cpc_regs.vh ====
// Constants for the calibrator panel controller.
// Assumes inclusion by bare name from the design file.
`ifndef CPC_REGS_VH
`define CPC_REGS_VH
`define CPC_FN_DCV      3'h0
`define CPC_FN_ACV      3'h1
`define CPC_FN_DCI      3'h2
`define CPC_FN_ACI      3'h3
`define CPC_FN_OHM      3'h4
`define CPC_RANGE_W     3
`define CPC_RANGE_DEF   3'h4
`define CPC_ERR_NONE    4'h0
`define CPC_ERR_BAD     4'h8
`define CPC_ERR_FAIL    4'h5
`define CPC_BUZZ_NS     100000
`define CPC_CLK_NS      100
`define CPC_BUZZ_CYC    ((`CPC_BUZZ_NS + `CPC_CLK_NS - 1) / `CPC_CLK_NS)
`endif

// ==== verilog/cpc_panel_ctrl.v ====
// Front-panel control state machine for a multifunction calibrator.
// Assumes keys and trip/remote levels are asynchronous pins; per-range availability (i_range_ok) lives elsewhere.
`include "cpc_regs.vh"
`default_nettype none
module cpc_panel_ctrl #(
  parameter HAS_DCV  = 1,
  parameter BUZZ_CYC = `CPC_BUZZ_CYC
) (
  input  wire                    i_sys_clk,
  input  wire                    i_sys_rst,
  input  wire                    i_key_dc,
  input  wire                    i_key_ac,
  input  wire                    i_key_ohm,
  input  wire                    i_key_cur,
  input  wire                    i_key_on_pos,
  input  wire                    i_key_on_neg,
  input  wire                    i_key_off,
  input  wire                    i_key_reset,
  input  wire                    i_key_up,
  input  wire                    i_key_down,
  input  wire                    i_key_guard,
  input  wire                    i_key_sense,
  input  wire                    i_key_range,
  input  wire [`CPC_RANGE_W-1:0] i_range_sel,
  input  wire [7:0]              i_range_ok,
  input  wire                    i_fault,
  input  wire                    i_remote,
  input  wire                    i_test_mode,
  input  wire                    i_selftest_done,
  input  wire                    external_reset_in_n,
  output reg  [2:0]              o_function,
  output reg  [`CPC_RANGE_W-1:0] o_range,
  output reg  [15:0]             o_value,
  output reg                     o_value_neg,
  output reg                     o_out_connect,
  output reg                     o_out_neg,
  output reg                     o_rem_guard,
  output reg                     o_rem_sense,
  output reg  [3:0]              o_err_code,
  output reg                     o_buzzer,
  output reg                     o_led_off,
  output reg                     o_led_on_pos,
  output reg                     o_led_on_neg,
  output reg                     o_led_dc,
  output reg                     o_led_ac,
  output reg                     o_led_ohm,
  output reg                     o_led_cur,
  output reg                     o_led_reset,
  output reg  [7:0]              o_led_range,
  output reg                     o_tripped
);
  localparam ST_INIT  = 3'b001;
  localparam ST_RUN   = 3'b010;
  localparam ST_TRIP  = 3'b100;
  localparam NK = 16;

  // Two-flop synchronisers for every asynchronous level.
  wire [NK-1:0] raw_in = {i_key_dc, i_key_ac, i_key_ohm, i_key_cur, i_key_on_pos,
    i_key_on_neg, i_key_off, i_key_reset, i_key_up, i_key_down, i_key_guard,
    i_key_sense, i_key_range, i_fault, i_remote, ~external_reset_in_n};
  reg  [NK-1:0] sync1_ff;
  reg  [NK-1:0] sync2_ff;
  reg  [NK-1:0] prev_ff;
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sync1_ff <= 16'h0000;
      sync2_ff <= 16'h0000;
      prev_ff  <= 16'h0000;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end
  wire [NK-1:0] press = sync2_ff & ~prev_ff;
  wire k_dc = press[15], k_ac = press[14], k_ohm = press[13], k_cur = press[12];
  wire k_pos = press[11], k_neg = press[10], k_off = press[9], k_rst = press[8];
  wire k_up = press[7], k_dn = press[6], k_grd = press[5], k_sns = press[4];
  wire k_rng = press[3];
  wire fault = sync2_ff[2];
  wire remote = sync2_ff[1];
  wire ext_rst = press[0];
  wire cur_held = sync2_ff[12];
  // Range 5 is the highest range the current functions (DCI, ACI) accept here.
  function rng_ok;
    input [2:0] fn;
    input [2:0] rg;
    begin
      case (fn)
        `CPC_FN_DCI, `CPC_FN_ACI: rng_ok = (rg <= 3'h5) && i_range_ok[rg];
        `CPC_FN_ACV:              rng_ok = (rg != 3'h0) && i_range_ok[rg];
        default:                  rng_ok = i_range_ok[rg];
      endcase
    end
  endfunction
  function is_dc;
    input [2:0] fn;
    begin
      is_dc = (fn == `CPC_FN_DCV) || (fn == `CPC_FN_DCI);
    end
  endfunction
  wire [2:0] def_fn = HAS_DCV ? `CPC_FN_DCV : `CPC_FN_ACV;
  reg [2:0]  st_ff;
  reg [2:0]  fn_ff;
  reg [2:0]  rg_ff;
  reg [15:0] val_ff;
  reg        vneg_ff;
  reg        on_ff;
  reg        oneg_ff;
  reg        grd_ff;
  reg        sns_ff;
  reg [3:0]  err_ff;
  reg [31:0] buzz_ff;
  reg [2:0]  nxt_st;
  reg [2:0]  nxt_fn;
  reg [2:0]  nxt_rg;
  reg [15:0] nxt_val;
  reg        nxt_vneg;
  reg        nxt_on;
  reg        nxt_oneg;
  reg        nxt_grd;
  reg        nxt_sns;
  reg [3:0]  nxt_err;
  reg        bad;
  reg [2:0]  want_fn;
  reg        fn_key;
  always @* begin
    nxt_st = st_ff;
    nxt_fn = fn_ff;
    nxt_rg = rg_ff;
    nxt_val = val_ff;
    nxt_vneg = vneg_ff;
    nxt_on = on_ff;
    nxt_oneg = oneg_ff;
    nxt_grd = grd_ff;
    nxt_sns = sns_ff;
    nxt_err = err_ff;
    bad = 1'b0;
    fn_key = k_dc | k_ac | k_ohm;
    want_fn = fn_ff;
    if (k_ohm)
      want_fn = `CPC_FN_OHM;
    else if (k_dc)
      want_fn = cur_held ? `CPC_FN_DCI : `CPC_FN_DCV;
    else if (k_ac)
      want_fn = cur_held ? `CPC_FN_ACI : `CPC_FN_ACV;
    case (st_ff)
      ST_INIT: begin
        if (i_selftest_done)
          nxt_st = ST_RUN;
      end
      ST_RUN: begin
        if (fault) begin
          nxt_st = ST_TRIP;
          nxt_on = 1'b0;
          nxt_err = `CPC_ERR_FAIL;
        end else if (ext_rst || (k_rst && !remote && !i_test_mode)) begin
          nxt_fn = def_fn;
          nxt_rg = `CPC_RANGE_DEF;
          nxt_val = 16'h0000;
          nxt_vneg = 1'b0;
          nxt_on = 1'b0;
          nxt_oneg = 1'b0;
          nxt_grd = 1'b0;
          nxt_sns = 1'b0;
          nxt_err = `CPC_ERR_NONE;
        end else if (!remote) begin
          if (fn_key) begin
            if (!rng_ok(want_fn, rg_ff)) begin
              bad = 1'b1;
            end else begin
              nxt_err = `CPC_ERR_NONE;
              if (want_fn != fn_ff)
                nxt_on = 1'b0;
              if (fn_ff == `CPC_FN_OHM && want_fn != `CPC_FN_OHM) begin
                nxt_val = 16'h0000;
                nxt_vneg = 1'b0;
              end
              nxt_fn = want_fn;
              if (want_fn == `CPC_FN_OHM)
                nxt_sns = 1'b1;
            end
          end else if (k_pos) begin
            nxt_on = 1'b1;
            nxt_oneg = 1'b0;
            nxt_err = `CPC_ERR_NONE;
          end else if (k_neg) begin
            if (is_dc(fn_ff)) begin
              nxt_on = 1'b1;
              nxt_oneg = 1'b1;
              nxt_err = `CPC_ERR_NONE;
            end else
              bad = 1'b1;
          end else if (k_off) begin
            nxt_on = 1'b0;
          end else if (k_rng) begin
            if (rng_ok(fn_ff, i_range_sel)) begin
              nxt_rg = i_range_sel;
              nxt_err = `CPC_ERR_NONE;
            end else
              bad = 1'b1;
          end else if (k_up || k_dn) begin
            // Sign-magnitude stepping; crossing zero flips terminal polarity in DC.
            if ((k_up == vneg_ff) && val_ff == 16'h0000) begin
              if (is_dc(fn_ff)) begin
                nxt_val = 16'h0001;
                nxt_vneg = ~vneg_ff;
                nxt_oneg = ~oneg_ff;
              end else
                bad = 1'b1;
            end else if (k_up == vneg_ff)
              nxt_val = val_ff - 16'h0001;
            else if (val_ff != 16'hffff)
              nxt_val = val_ff + 16'h0001;
            else
              bad = 1'b1;
          end else if (k_grd) begin
            nxt_grd = ~grd_ff;
          end else if (k_sns) begin
            if (fn_ff == `CPC_FN_OHM)
              bad = 1'b1;
            else
              nxt_sns = ~sns_ff;
          end
          if (bad)
            nxt_err = `CPC_ERR_BAD;
        end
      end
      ST_TRIP: begin
        // Keys other than Reset are ignored; recovery keeps setup, output off.
        if (k_rst && !fault) begin
          nxt_st = ST_RUN;
          nxt_err = `CPC_ERR_NONE;
        end
        nxt_on = 1'b0;
      end
      default: nxt_st = ST_INIT;
    endcase
  end
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_ff <= ST_INIT;
      fn_ff <= `CPC_FN_DCV;
      rg_ff <= `CPC_RANGE_DEF;
      val_ff <= 16'h0000;
      vneg_ff <= 1'b0;
      on_ff <= 1'b0;
      oneg_ff <= 1'b0;
      grd_ff <= 1'b0;
      sns_ff <= 1'b0;
      err_ff <= `CPC_ERR_NONE;
      buzz_ff <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
      fn_ff <= (st_ff == ST_INIT) ? def_fn : nxt_fn;
      rg_ff <= nxt_rg;
      val_ff <= nxt_val;
      vneg_ff <= nxt_vneg;
      on_ff <= nxt_on;
      oneg_ff <= nxt_oneg;
      grd_ff <= nxt_grd;
      sns_ff <= nxt_sns;
      err_ff <= nxt_err;
      if (bad || (st_ff == ST_RUN && fault))
        buzz_ff <= BUZZ_CYC;
      else if (buzz_ff != 32'h0000_0000)
        buzz_ff <= buzz_ff - 32'h0000_0001;
    end
  end
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_function <= `CPC_FN_DCV;
      o_range <= `CPC_RANGE_DEF;
      o_value <= 16'h0000;
      o_value_neg <= 1'b0;
      o_out_connect <= 1'b0;
      o_out_neg <= 1'b0;
      o_rem_guard <= 1'b0;
      o_rem_sense <= 1'b0;
      o_err_code <= `CPC_ERR_NONE;
      o_buzzer <= 1'b0;
      o_led_off <= 1'b1;
      o_led_on_pos <= 1'b0;
      o_led_on_neg <= 1'b0;
      o_led_dc <= 1'b0;
      o_led_ac <= 1'b0;
      o_led_ohm <= 1'b0;
      o_led_cur <= 1'b0;
      o_led_reset <= 1'b0;
      o_led_range <= 8'h00;
      o_tripped <= 1'b0;
    end else begin
      o_function <= fn_ff;
      o_range <= rg_ff;
      o_value <= val_ff;
      o_value_neg <= vneg_ff;
      o_out_connect <= on_ff;
      o_out_neg <= on_ff & oneg_ff;
      o_rem_guard <= grd_ff;
      o_rem_sense <= sns_ff;
      o_err_code <= err_ff;
      o_buzzer <= (buzz_ff != 32'h0000_0000);
      o_led_off <= ~on_ff;
      o_led_on_pos <= on_ff & ~oneg_ff;
      o_led_on_neg <= on_ff & oneg_ff;
      o_led_dc <= is_dc(fn_ff);
      o_led_ac <= (fn_ff == `CPC_FN_ACV) || (fn_ff == `CPC_FN_ACI);
      o_led_ohm <= (fn_ff == `CPC_FN_OHM);
      o_led_cur <= (fn_ff == `CPC_FN_DCI) || (fn_ff == `CPC_FN_ACI);
      o_led_reset <= i_test_mode;
      o_led_range <= 8'h01 << rg_ff;
      o_tripped <= (st_ff == ST_TRIP);
    end
  end
endmodule // cpc_panel_ctrl
`default_nettype wire

// ==== test/cpc_panel_ctrl_properties.sv ====
// Port-level checks for the panel controller.
// Assumes one clock and the synchronous active-high reset.
`include "cpc_regs.vh"
`default_nettype none
module cpc_panel_ctrl_properties (
  input wire logic       i_sys_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_key_reset,
  input wire logic       i_test_mode,
  input wire logic       external_reset_in_n,
  input wire logic [2:0] o_function,
  input wire logic       o_out_connect,
  input wire logic       o_out_neg,
  input wire logic       o_rem_sense,
  input wire logic [3:0] o_err_code,
  input wire logic       o_buzzer,
  input wire logic       o_led_off,
  input wire logic       o_led_on_pos,
  input wire logic       o_led_on_neg,
  input wire logic       o_led_reset,
  input wire logic       o_tripped
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  a_off_led_match: assert property (o_led_off == !o_out_connect)
    else $error("off LED disagrees with terminals");
  a_polarity_leds: assert property (o_out_connect |->
    (o_led_on_neg == o_out_neg) && (o_led_on_pos == !o_out_neg))
    else $error("polarity LEDs disagree with terminals");
  a_reset_led_dark: assert property ((!i_test_mode) [*4] |-> !o_led_reset)
    else $error("reset LED lit outside test mode");
  a_trip_output_off: assert property (o_tripped && $past(o_tripped) |->
    !o_out_connect && o_err_code == `CPC_ERR_FAIL)
    else $error("trip without output off and fail code");
  a_trip_latched: assert property
    ((o_tripped && !i_key_reset && external_reset_in_n) [*6] |=> o_tripped)
    else $error("trip cleared without reset");
  a_fn_change_off: assert property (o_function != $past(o_function) |-> !o_out_connect)
    else $error("function changed with output on");
  a_ohm_sense_on: assert property ((o_function == `CPC_FN_OHM) [*2] |-> o_rem_sense)
    else $error("ohms without remote sense");
  a_ac_no_negative: assert property ((o_function != `CPC_FN_DCV) &&
    (o_function != `CPC_FN_DCI) && o_out_connect |-> !o_out_neg)
    else $error("negative output outside dc functions");
  a_error_buzzes: assert property
    ($changed(o_err_code) && o_err_code == `CPC_ERR_BAD |-> ##[0:2] o_buzzer)
    else $error("error code without buzzer");
  cover property ($rose(o_tripped));
  cover property (o_err_code == `CPC_ERR_BAD && o_buzzer);
  cover property (o_out_connect && o_out_neg);
endmodule // cpc_panel_ctrl_properties
bind cpc_panel_ctrl cpc_panel_ctrl_properties u_cpc_panel_ctrl_properties (
  .i_sys_clk, .i_sys_rst, .i_key_reset, .i_test_mode, .external_reset_in_n, .o_function,
  .o_out_connect, .o_out_neg, .o_rem_sense, .o_err_code, .o_buzzer, .o_led_off,
  .o_led_on_pos, .o_led_on_neg, .o_led_reset, .o_tripped);
`default_nettype wire

// ==== test/cpc_panel_operator.sv ====
// Operator model: front-panel key levels and the external reset pin.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`default_nettype none
module cpc_panel_operator (
  input  wire logic        i_sys_clk,
  output var  logic [12:0] o_keys,
  output var  logic        o_ext_rst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_keys = 13'h0000;
    o_ext_rst_n = 1'h1;
  end
  // A press outlasts the synchroniser and edge flop; the gap lets the outputs settle.
  task automatic press(input int idx, input logic cur);
    @(negedge i_sys_clk) o_keys = (13'h0001 << idx) | {9'h000, cur, 3'h0};
    repeat (4) @(negedge i_sys_clk);
    o_keys = 13'h0000;
    repeat (8) @(negedge i_sys_clk);
  endtask
  task automatic pulse_ext_reset();
    @(negedge i_sys_clk) o_ext_rst_n = 1'h0;
    repeat (4) @(negedge i_sys_clk);
    o_ext_rst_n = 1'h1;
    repeat (8) @(negedge i_sys_clk);
  endtask
endmodule // cpc_panel_operator
`default_nettype wire

// ==== test/cpc_panel_ctrl_test.sv ====
// Bench for the panel controller: key table, then reset, remote and trip cases.
// Assumes the operator model drives every key on the falling edge.
`default_nettype none
module cpc_panel_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_sys_clk, i_sys_rst, i_fault, i_remote, i_test_mode, i_selftest_done;
  logic [2:0]  i_range_sel, o_function, o_range;
  logic [15:0] o_value;
  logic [3:0]  o_err_code;
  logic [7:0]  o_led_range, i_range_ok;
  logic        o_value_neg, o_out_connect, o_out_neg, o_rem_guard, o_rem_sense, o_buzzer;
  logic        o_led_off, o_led_on_pos, o_led_on_neg, o_led_dc, o_led_ac, o_led_ohm;
  logic        o_led_cur, o_led_reset, o_tripped, ext_n;
  logic [12:0] k;
  int          mismatches, checks_done, buzz_mark;
  int          buzz_cycles = 0;
  localparam int BUZZ = 4;
  // Columns: key, current held, function, connected, negative, error code.
  localparam logic [13:0] ROWS [14] = '{14'h1020, 14'h1800, 14'h1430, 14'h0440, 14'h1448,
    14'h1060, 14'h0900, 14'h2100, 14'h0000, 14'h0280, 14'h06C0, 14'h0000, 14'h1020, 14'h2430};
  localparam logic [31:0] DEF = {6'h00, 3'h4, 3'h3, 12'h000, 8'h10};
  cpc_panel_ctrl #(.HAS_DCV(1), .BUZZ_CYC(BUZZ)) u_cpc_panel_ctrl (
    .i_sys_clk, .i_sys_rst, .i_key_dc(k[0]), .i_key_ac(k[1]), .i_key_ohm(k[2]),
    .i_key_cur(k[3]), .i_key_on_pos(k[4]), .i_key_on_neg(k[5]), .i_key_off(k[6]),
    .i_key_reset(k[7]), .i_key_up(k[8]), .i_key_down(k[9]), .i_key_guard(k[10]),
    .i_key_sense(k[11]), .i_key_range(k[12]), .i_range_sel, .i_range_ok,
    .i_fault, .i_remote, .i_test_mode, .i_selftest_done, .external_reset_in_n(ext_n),
    .o_function, .o_range, .o_value, .o_value_neg, .o_out_connect, .o_out_neg,
    .o_rem_guard, .o_rem_sense, .o_err_code, .o_buzzer, .o_led_off, .o_led_on_pos,
    .o_led_on_neg, .o_led_dc, .o_led_ac, .o_led_ohm, .o_led_cur, .o_led_reset,
    .o_led_range, .o_tripped);
  cpc_panel_operator u_cpc_panel_operator (.i_sys_clk, .o_keys(k), .o_ext_rst_n(ext_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] state_word();
    return {3'h0, o_function, o_range, o_out_connect, o_led_off, o_led_dc, o_led_ac,
            o_led_ohm, o_led_cur, o_led_on_pos, o_led_on_neg, o_rem_guard, o_rem_sense,
            o_led_reset, o_err_code, o_led_range};
  endfunction
  // Function key LEDs as {dc, ac, ohms, current} for each function code.
  function automatic logic [3:0] fn_leds(input logic [2:0] fn);
    case (fn)
      3'h0: return 4'h8;
      3'h1: return 4'h4;
      3'h2: return 4'h9;
      3'h3: return 4'h5;
      default: return 4'h2;
    endcase
  endfunction
  // Counting buzzer cycles lets a short buzz be checked after the key is released.
  always @(posedge i_sys_clk) begin
    if (o_buzzer === 1'h1) buzz_cycles <= buzz_cycles + 1;
  end
  initial begin
    i_sys_clk = 1'h0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  initial begin
    {i_sys_rst, i_fault, i_remote, i_test_mode, i_selftest_done} = 5'h10;
    i_range_sel = 3'h4;
    i_range_ok = 8'hff;
    mismatches = 0;
    checks_done = 0;
    repeat (4) @(negedge i_sys_clk);
    i_sys_rst = 1'h0;
    i_selftest_done = 1'h1;
    repeat (6) @(negedge i_sys_clk);
    check(state_word(), DEF);
    for (int r = 0; r < 14; r++) begin
      buzz_mark = buzz_cycles;
      u_cpc_panel_operator.press(ROWS[r][13:10], ROWS[r][9]);
      check(o_function, ROWS[r][8:6]);
      check({o_out_connect, o_out_neg & o_out_connect}, ROWS[r][5:4]);
      check(o_err_code, ROWS[r][3:0]);
      check(buzz_cycles - buzz_mark, (ROWS[r][3:0] == 4'h8) ? BUZZ : 0);
      check({o_led_on_neg, o_led_on_pos}, ROWS[r][5] ? {ROWS[r][4], !ROWS[r][4]} : 2'h0);
      check({o_led_dc, o_led_ac, o_led_ohm, o_led_cur}, fn_leds(ROWS[r][8:6]));
      if (r == 8) check(o_value, 16'h0000);
      if (r == 13) check({o_value, o_value_neg}, {16'h0001, 1'h1});
    end
    i_range_sel = 3'h6;
    i_range_ok = 8'hbf;
    u_cpc_panel_operator.press(12, 1'h0);
    check({o_range, o_err_code}, {3'h4, 4'h8});
    i_range_ok = 8'hff;
    u_cpc_panel_operator.press(12, 1'h0);
    check({o_range, o_led_range, o_err_code}, {3'h6, 8'h40, 4'h0});
    u_cpc_panel_operator.press(0, 1'h1);
    check({o_function, o_err_code}, {3'h0, 4'h8});
    u_cpc_panel_operator.press(10, 1'h0);
    check(o_rem_guard, 1'h1);
    u_cpc_panel_operator.press(7, 1'h0);
    check(state_word(), DEF);
    u_cpc_panel_operator.press(4, 1'h0);
    i_remote = 1'h1;
    u_cpc_panel_operator.press(7, 1'h0);
    check(o_out_connect, 1'h1);
    u_cpc_panel_operator.pulse_ext_reset();
    check(state_word(), DEF);
    i_remote = 1'h0;
    i_range_sel = 3'h2;
    u_cpc_panel_operator.press(12, 1'h0);
    u_cpc_panel_operator.press(4, 1'h0);
    i_fault = 1'h1;
    repeat (8) @(negedge i_sys_clk);
    check({o_tripped, o_out_connect, o_err_code}, {2'h2, 4'h5});
    u_cpc_panel_operator.press(7, 1'h0);
    check(o_tripped, 1'h1);
    i_fault = 1'h0;
    u_cpc_panel_operator.press(4, 1'h0);
    check({o_tripped, o_out_connect}, 2'h2);
    u_cpc_panel_operator.press(7, 1'h0);
    check({o_tripped, o_out_connect, o_range}, {2'h0, 3'h2});
    i_test_mode = 1'h1;
    u_cpc_panel_operator.press(4, 1'h0);
    u_cpc_panel_operator.press(7, 1'h0);
    check({o_led_reset, o_out_connect}, 2'h3);
    i_test_mode = 1'h0;
    u_cpc_panel_operator.press(7, 1'h0);
    check(state_word(), DEF);
    finish_test();
  end
endmodule // cpc_panel_ctrl_test
`default_nettype wire
